// *** include/supply_supervisor_defines.svh ***
// timing and reset constants of the microcontroller supply supervisor
`ifndef SUPPLY_SUPERVISOR_DEFINES_SVH
`define SUPPLY_SUPERVISOR_DEFINES_SVH
`define SYS_CLK_PERIOD_NS  4
`define NS_PER_MS          1000000
`define RESET_PULSE_MS     1
`define WD_MS_1   8'd5
`define WD_MS_2   8'd10
`define WD_MS_3   8'd20
`define WD_MS_4   8'd32
`define WD_MS_5   8'd51
`define WD_MS_6   8'd74
`define WD_MS_7   8'd100
`define WD_MS_8   8'd202
`define CY_MS_1   14'd32
`define CY_MS_2   14'd64
`define CY_MS_3   14'd128
`define CY_MS_4   14'd256
`define CY_MS_5   14'd512
`define CY_MS_6   14'd1024
`define CY_MS_7   14'd2048
`define CY_MS_8   14'd8192
`define STATUS_RESET_VAL   3'h0
`endif

// *** include/supply_supervisor_pkg.sv ***
// types shared by the microcontroller supply supervisor
package supply_supervisor_pkg;
  typedef enum logic [1:0] {
    post_power_on_request_mode, normal_mode, standby_mode, sleep_mode
  } op_mode_e;
  typedef struct packed {
    logic uv_reset;    // reset_source_status: supply undervoltage reset
    logic ot_prewarn;  // overtemp_status: pre-warning reached
    logic ot_shutdown; // overtemp_status: shut-off reached
  } status_s;
endpackage

// *** hw/mcu_supply_supervisor.sv ***
// microcontroller supply supervisor: enable, reset pulse, thermal, timers
`timescale 1ns/1ps
`include "supply_supervisor_defines.svh"
module mcu_supply_supervisor
  import supply_supervisor_pkg::*;
#(
  parameter int MS_CYCLES = `NS_PER_MS / `SYS_CLK_PERIOD_NS,
  parameter int RESET_CYCLES = `RESET_PULSE_MS * MS_CYCLES
) (
  input  wire logic     sys_clk,
  input  wire logic     rst,
  input  wire logic     supply_uv,       // pin: supply below threshold
  input  wire logic     temp_prewarn,    // pin: pass transistor >= 145 C
  input  wire logic     temp_shutoff,    // pin: pass transistor >= 175 C
  input  wire logic     battery_ok,      // pin: battery supply present
  input  wire op_mode_e mode,            // mode written over SPI
  input  wire logic     emergency,       // emergency mode active
  input  wire logic     status_clear,    // pulse: clear selected flags
  input  wire status_s  status_clear_sel,
  input  wire logic [1:0] ot_int_mask,   // [0] prewarn, [1] shutdown
  input  wire logic [2:0] wd_sel,        // watchdog period code
  input  wire logic [2:0] cy_sel,        // cyclic period code
  input  wire logic     wd_kick,         // pulse: watchdog refresh
  output logic          mcu_supply_regulator,
  output logic          reset_out_n,
  output status_s       status,
  output logic          ot_int,
  output logic          wd_timeout,      // pulse on watchdog expiry
  output logic          forced_wakeup    // pulse each cyclic period
);

  // two-flop synchronisers for the analog comparator pins
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  always_ff @(posedge sys_clk) begin
    pin_meta_reg <= {supply_uv, temp_prewarn, temp_shutoff, battery_ok};
    pin_sync_reg <= pin_meta_reg;
  end
  wire uv_s      = pin_sync_reg[3];
  wire prewarn_s = pin_sync_reg[2];
  wire shutoff_s = pin_sync_reg[1];
  wire batt_s    = pin_sync_reg[0];

  // thermal shutdown latch: held until back below pre-warning level
  logic shut_reg;
  wire  shut_next = shutoff_s | (shut_reg & prewarn_s);
  always_ff @(posedge sys_clk) begin
    if (rst) shut_reg <= 1'b0;
    else     shut_reg <= shut_next;
  end

  // regulator enable decode
  wire mode_on = (mode != sleep_mode);
  wire reg_on_next = mode_on & ~emergency & batt_s & ~shut_next;
  always_ff @(posedge sys_clk) begin
    if (rst) mcu_supply_regulator <= 1'b0;
    else     mcu_supply_regulator <= reg_on_next;
  end

  // reset pulse: held low during undervoltage, then for the pulse time
  logic [31:0] rst_cnt_reg;
  logic        uv_prev_reg;
  wire   uv_rise   = uv_s & ~uv_prev_reg;
  wire   rst_busy  = (rst_cnt_reg != 32'd0);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_cnt_reg <= 32'd0;
      uv_prev_reg <= 1'b0;
      reset_out_n <= 1'b0;
    end else begin
      uv_prev_reg <= uv_s;
      if (uv_s) rst_cnt_reg <= 32'(RESET_CYCLES);
      else if (rst_busy) rst_cnt_reg <= rst_cnt_reg - 32'd1;
      reset_out_n <= ~(uv_s | rst_busy);
    end
  end

  // sticky flags: a set in the clear cycle wins over the clear
  status_s set_ev;
  assign set_ev = '{uv_reset: uv_rise, ot_prewarn: prewarn_s,
                    ot_shutdown: shutoff_s};
  status_s clr_ev;
  assign clr_ev = status_clear ? status_clear_sel : status_s'(3'h0);
  status_s status_next;
  assign status_next = (status & ~clr_ev) | set_ev;
  always_ff @(posedge sys_clk) begin
    if (rst) status <= `STATUS_RESET_VAL;
    else     status <= status_next;
  end
  assign ot_int = (status.ot_prewarn & ~ot_int_mask[0]) |
                  (status.ot_shutdown & ~ot_int_mask[1]);

  // millisecond ticks standing in for the two internal oscillators;
  // only one runs at a time, as the mode decides
  logic [31:0] ms_cnt_reg;
  wire ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));
  always_ff @(posedge sys_clk) begin
    if (rst || ms_tick) ms_cnt_reg <= 32'd0;
    else                ms_cnt_reg <= ms_cnt_reg + 32'd1;
  end
  wire run_tick   = ms_tick & mode_on;
  wire sleep_tick = ms_tick & ~mode_on;

  // period lookup from the selection codes
  logic [7:0]  wd_limit;
  logic [13:0] cy_limit;
  always_comb begin
    case (wd_sel)
      3'h0:    wd_limit = `WD_MS_1;
      3'h1:    wd_limit = `WD_MS_2;
      3'h2:    wd_limit = `WD_MS_3;
      3'h3:    wd_limit = `WD_MS_4;
      3'h4:    wd_limit = `WD_MS_5;
      3'h5:    wd_limit = `WD_MS_6;
      3'h6:    wd_limit = `WD_MS_7;
      default: wd_limit = `WD_MS_8;
    endcase
    case (cy_sel)
      3'h0:    cy_limit = `CY_MS_1;
      3'h1:    cy_limit = `CY_MS_2;
      3'h2:    cy_limit = `CY_MS_3;
      3'h3:    cy_limit = `CY_MS_4;
      3'h4:    cy_limit = `CY_MS_5;
      3'h5:    cy_limit = `CY_MS_6;
      3'h6:    cy_limit = `CY_MS_7;
      default: cy_limit = `CY_MS_8;
    endcase
  end

  // watchdog: restarted by a kick, held cleared outside running modes
  logic [7:0] wd_cnt_reg;
  wire wd_end = run_tick & (wd_cnt_reg >= wd_limit - 8'd1);
  always_ff @(posedge sys_clk) begin
    if (rst || wd_kick || !mode_on || wd_end) wd_cnt_reg <= 8'd0;
    else if (run_tick) wd_cnt_reg <= wd_cnt_reg + 8'd1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) wd_timeout <= 1'b0;
    else     wd_timeout <= wd_end & ~wd_kick;
  end

  // cyclic sense timer: counts only while asleep
  logic [13:0] cy_cnt_reg;
  wire cy_end = sleep_tick & (cy_cnt_reg >= cy_limit - 14'd1);
  always_ff @(posedge sys_clk) begin
    if (rst || mode_on || cy_end) cy_cnt_reg <= 14'd0;
    else if (sleep_tick) cy_cnt_reg <= cy_cnt_reg + 14'd1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) forced_wakeup <= 1'b0;
    else     forced_wakeup <= cy_end;
  end

  // checks
  AST_RST_LOW_UV: assert property (@(posedge sys_clk)
    disable iff (rst) uv_s |=> !reset_out_n)
    else $error("reset high during undervoltage");
  AST_RST_PULSE: assert property (@(posedge sys_clk)
    disable iff (rst) $fell(uv_s) |=> !reset_out_n [*2])
    else $error("reset pulse cut short");
  // the pulse is far too long for a delay, so watch the counter load
  AST_PULSE_LOAD: assert property (@(posedge sys_clk)
    disable iff (rst) $fell(uv_s) |-> rst_cnt_reg == 32'(RESET_CYCLES))
    else $error("pulse count not loaded at recovery");
  AST_RST_HIGH: assert property (@(posedge sys_clk)
    disable iff (rst) !uv_s && !rst_busy |=> reset_out_n)
    else $error("reset held past the pulse");
  AST_FLAG_HOLD: assert property (@(posedge sys_clk)
    disable iff (rst) status.uv_reset && !status_clear |=> status.uv_reset)
    else $error("source flag lost without clear");
  AST_UV_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
    uv_rise |=> status.uv_reset) else $error("source flag not set");
  AST_PREWARN: assert property (@(posedge sys_clk) disable iff (rst)
    prewarn_s |=> status.ot_prewarn && (ot_int || ot_int_mask[0]))
    else $error("prewarn flag or interrupt missing");
  // the interrupt is combinational, so a full mask must silence it at once
  AST_INT_MASK: assert property (@(posedge sys_clk)
    disable iff (rst) ot_int_mask == 2'h3 |-> !ot_int)
    else $error("interrupt through full mask");
  AST_REG_ON: assert property (@(posedge sys_clk)
    disable iff (rst) mode_on && !emergency && batt_s && !shutoff_s
    && !shut_reg |=> mcu_supply_regulator)
    else $error("regulator off in on condition");
  AST_SHUTOFF: assert property (@(posedge sys_clk) disable iff (rst)
    shutoff_s |=> !mcu_supply_regulator && status.ot_shutdown)
    else $error("regulator on at shut-off");
  AST_RESTART: assert property (@(posedge sys_clk) disable iff (rst)
    shut_reg && !prewarn_s && !shutoff_s && mode_on && !emergency
    && batt_s |=> mcu_supply_regulator)
    else $error("no automatic restart");
  AST_SLEEP_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    mode == sleep_mode || emergency || !batt_s |=> !mcu_supply_regulator)
    else $error("regulator on in off condition");
  AST_WD_BOUND: assert property (@(posedge sys_clk) disable iff (rst)
    wd_cnt_reg < `WD_MS_8) else $error("watchdog count past limit");
  AST_CY_SLEEP: assert property (@(posedge sys_clk) disable iff (rst)
    forced_wakeup |-> $past(mode) == sleep_mode)
    else $error("cyclic event outside sleep");
  AST_WD_PULSE: assert property (@(posedge sys_clk)
    disable iff (rst) wd_timeout |=> !wd_timeout)
    else $error("watchdog pulse longer than one cycle");
  AST_WD_SLEEP: assert property (@(posedge sys_clk)
    disable iff (rst) !mode_on |=> !wd_timeout)
    else $error("watchdog expiry while asleep");
  AST_CY_PULSE: assert property (@(posedge sys_clk)
    disable iff (rst) forced_wakeup |=> !forced_wakeup)
    else $error("wake-up pulse longer than one cycle");
  COV_UV_PULSE: cover property (@(posedge sys_clk) $rose(reset_out_n));
  COV_SHUTDOWN: cover property (@(posedge sys_clk)
    $fell(mcu_supply_regulator) && status.ot_shutdown);
  COV_WD: cover property (@(posedge sys_clk) wd_timeout);
  COV_CY: cover property (@(posedge sys_clk) forced_wakeup);
  COV_RESTART: cover property (@(posedge sys_clk)
    $rose(mcu_supply_regulator) && status.ot_shutdown);

endmodule // mcu_supply_supervisor

// *** verification/mcu_model.sv ***
// microcontroller stand-in that times the reset it is held in
`timescale 1ns/1ps
module mcu_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_out_n,
  output logic [15:0]      rst_len
);
  logic [15:0] run_cnt = 16'h0;
  // only a release edge ends a count, so a stuck reset never reports
  always @(posedge sys_clk) begin
    if (reset_out_n === 1'b0) begin
      run_cnt <= run_cnt + 16'h1;
    end else begin
      if (run_cnt != 16'h0) rst_len <= run_cnt;
      run_cnt <= 16'h0;
    end
  end
endmodule // mcu_model

// *** verification/tb.sv ***
// self-checking bench of the microcontroller supply supervisor
`timescale 1ns/1ps
module tb;
  import supply_supervisor_pkg::*;
  localparam int MS = 4;
  localparam int RC = 10;
  logic sys_clk = 0, rst = 1, supply_uv = 0, temp_prewarn = 0;
  logic temp_shutoff = 0, battery_ok = 1, emergency = 0;
  logic status_clear = 0, wd_kick = 0;
  op_mode_e mode = normal_mode;
  status_s status_clear_sel = 3'h0, status;
  logic [1:0] ot_int_mask = 2'h0;
  logic [2:0] wd_sel = 3'h0, cy_sel = 3'h0;
  logic mcu_supply_regulator, reset_out_n, ot_int, wd_timeout, forced_wakeup;
  logic [15:0] rst_len;
  int errors = 0, comparisons = 0, n, wd_sleep = 0;
  int wd_ms[8] = '{5, 10, 20, 32, 51, 74, 100, 202};
  int cy_ms[8] = '{32, 64, 128, 256, 512, 1024, 2048, 8192};
  always #2 sys_clk = ~sys_clk;
  mcu_supply_supervisor #(.MS_CYCLES(MS), .RESET_CYCLES(RC)) uut (
    .sys_clk, .rst, .supply_uv, .temp_prewarn, .temp_shutoff, .battery_ok,
    .mode, .emergency, .status_clear, .status_clear_sel, .ot_int_mask,
    .wd_sel, .cy_sel, .wd_kick, .mcu_supply_regulator, .reset_out_n,
    .status, .ot_int, .wd_timeout, .forced_wakeup);
  mcu_model partner (.sys_clk, .reset_out_n, .rst_len);
  // a watchdog expiry while asleep would wake nobody, so count any
  always @(posedge sys_clk) begin
    if (mode == sleep_mode && wd_timeout === 1'b1) wd_sleep++;
  end
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // bounded wait: 0 reset released, 1 watchdog expiry, 2 forced wake-up
  task automatic await(input int s, input int lim, output int c);
    c = 0;
    while (!((s == 0 && reset_out_n === 1'b1) ||
             (s == 1 && wd_timeout === 1'b1) ||
             (s == 2 && forced_wakeup === 1'b1))) begin
      tick(1);
      c++;
      if (c > lim) begin
        errors++;
        $display("MISMATCH wait_%0d expected event seen none", s);
        results();
      end
    end
  endtask
  task automatic clear(input logic [2:0] sel);
    status_clear_sel = sel;
    status_clear = 1;
    tick(1);
    status_clear = 0;
    tick(2);
  endtask
  initial begin
    tick(5);
    rst = 0;
    await(0, 4 * RC, n);
    tick(4);
    chk("regulator_normal", 1, mcu_supply_regulator);
    supply_uv = 1;
    tick(6);
    chk("reset_in_uv", 0, reset_out_n);
    chk("uv_flag", 1, status.uv_reset);
    chk("regulator_in_reset", 1, mcu_supply_regulator);
    supply_uv = 0;
    await(0, 4 * RC, n);
    chk("reset_from_recovery", 1, n >= RC && n <= RC + 5);
    tick(2);
    chk("reset_len", 1, rst_len >= RC + 4 && rst_len <= RC + 12);
    clear(3'h4);
    chk("uv_flag_cleared", 0, status.uv_reset);
    temp_prewarn = 1;
    tick(4);
    chk("prewarn_flag", 1, status.ot_prewarn);
    chk("prewarn_irq", 1, ot_int);
    chk("regulator_prewarn", 1, mcu_supply_regulator);
    ot_int_mask = 2'h1;
    tick(1);
    chk("prewarn_masked", 0, ot_int);
    temp_shutoff = 1;
    tick(4);
    chk("shutdown_flag", 1, status.ot_shutdown);
    chk("shutdown_irq", 1, ot_int);
    chk("regulator_shutoff", 0, mcu_supply_regulator);
    ot_int_mask = 2'h3;
    tick(1);
    chk("shutdown_masked", 0, ot_int);
    temp_shutoff = 0;
    tick(6);
    chk("regulator_still_hot", 0, mcu_supply_regulator);
    temp_prewarn = 0;
    tick(4);
    chk("regulator_restart", 1, mcu_supply_regulator);
    ot_int_mask = 2'h0;
    clear(3'h7);
    chk("flags_cleared", 0, status);
    for (int i = 0; i < 4; i++) begin
      mode = op_mode_e'(i);
      tick(3);
      chk("regulator_mode", i != 3, mcu_supply_regulator);
    end
    mode = normal_mode;
    emergency = 1;
    tick(3);
    chk("regulator_emergency", 0, mcu_supply_regulator);
    emergency = 0;
    battery_ok = 0;
    tick(5);
    chk("regulator_no_battery", 0, mcu_supply_regulator);
    battery_ok = 1;
    tick(5);
    // kick then time the expiry; the ms prescaler phase costs one tick
    for (int i = 0; i < 8; i++) begin
      wd_sel = 3'(i);
      wd_kick = 1;
      tick(1);
      wd_kick = 0;
      await(1, 2000, n);
      chk("wd_period", 1, n >= wd_ms[i] * MS - MS - 4 &&
          n <= wd_ms[i] * MS + MS + 4);
      tick(2);
    end
    for (int i = 0; i < 8; i++) begin
      mode = normal_mode;
      cy_sel = 3'(i);
      tick(3);
      mode = sleep_mode;
      await(2, 40000, n);
      chk("cyclic_period", 1, n >= cy_ms[i] * MS - MS - 4 &&
          n <= cy_ms[i] * MS + MS + 4);
    end
    chk("wd_quiet_in_sleep", 0, 16'(wd_sleep));
    results();
  end
endmodule // tb
